// >>> adtg_pkg.sv
/*
 * Constants and carrier types for the dual unit trigger generator.
 * Assumes a 32-bit AXI4-Lite register bus and a 100 MHz core clock.
 */
package adtg_pkg;

   // ==========================================================
   // Register byte offsets
   localparam logic [7:0] REG_TRIG   = 8'h00; // dual_ctrl_reg1
   localparam logic [7:0] REG_MODE   = 8'h04; // dual_ctrl_reg2
   localparam logic [7:0] REG_DELAY  = 8'h08; // dual_ctrl_reg3
   localparam logic [7:0] REG_STATUS = 8'h0c; // Live state
   localparam logic [7:0] REG_SCAN   = 8'h10; // Scan ranges

   // ==========================================================
   // Field positions
   localparam int SW_TRIG_BIT  = 0;  // software_trigger_bit
   localparam int ILV_BIT      = 0;  // interleave_select
   localparam int EN_BIT       = 1;  // dual_trigger_enable
   localparam int SRC_LSB      = 2;  // trigger_source_select
   localparam int SCAN_A_START = 0;
   localparam int SCAN_A_WIDTH = 4;
   localparam int SCAN_B_START = 8;
   localparam int SCAN_B_WIDTH = 12;
   localparam int STS_WAIT_BIT = 0;  // Waiting for unit B trigger
   localparam int STS_NEXTB    = 1;  // Next event goes to unit B
   localparam int STS_BUSY_A   = 2;
   localparam int STS_BUSY_B   = 3;
   localparam int STS_VIOL     = 4;  // Sticky, write 1 to clear
   localparam int STS_CNT_LSB  = 8;

   // ==========================================================
   // Reset values and encodings
   localparam logic [31:0] WORD_ZERO   = 32'h0000_0000;
   localparam logic [1:0]  SRC_SW      = 2'h0;
   localparam logic [1:0]  SRC_TIMER   = 2'h1;
   localparam logic [1:0]  SRC_EXT     = 2'h2;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
   localparam logic [3:0]  LAST_CH     = 4'h3;

   // Mode bits carried together
   typedef struct packed {
      logic [1:0] src;        // Trigger source
      logic       enable;     // dual_trigger_enable
      logic       interleave; // interleave_select
   } adtg_mode_t;

   // Scan range for one unit; start sits in the low nibble
   typedef struct packed {
      logic [3:0] width;      // Extra channels after start
      logic [3:0] start;      // First channel code
   } adtg_scan_t;

   // Trigger generator state, Gray along IDLE -> WAIT_B
   typedef enum logic [0:0] {
      ST_IDLE   = 1'b0,
      ST_WAIT_B = 1'b1
   } adtg_state_t;

endpackage

// >>> adtg_source.sv
/*
 * Trigger source conditioner: synchronises the timer and external
 * trigger pins, detects their edges and picks the selected source.
 * Assumes the pins are asynchronous to core_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module adtg_source (
   // Clock and reset
   input  wire logic       core_clk,
   input  wire logic       reset,
   // Raw sources
   input  wire logic       timer_trig,
   input  wire logic       ext_trig,
   input  wire logic       sw_pulse,
   // Selection
   input  wire logic [1:0] src,
   input  wire logic       timer_fall,
   // Selected event, one cycle
   output logic            event_pulse
);

   // ==========================================================
   // Two-flop synchronisers plus one history stage per pin
   logic [1:0] meta;    // First stage, read by second only
   logic [1:0] sync;    // Second stage
   logic [1:0] hist;    // Previous synchronised value

   // Synchronise and remember
   always_ff @(posedge core_clk) begin
      if (reset) begin
         meta <= 2'h0;
         sync <= 2'h0;
         hist <= 2'h0;
      end else begin
         meta <= {ext_trig, timer_trig};
         sync <= meta;
         hist <= sync;
      end
   end

   // ==========================================================
   // Edge detection and selection
   logic timer_rise;    // Timer rising edge
   logic timer_drop;    // Timer falling edge
   logic ext_rise;      // External rising edge
   logic timer_event;   // Timer edge in use

   assign timer_rise  = sync[0] & ~hist[0];
   assign timer_drop  = ~sync[0] & hist[0];
   assign ext_rise    = sync[1] & ~hist[1];
   // Trigger start mode watches the falling edge
   assign timer_event = timer_fall ? timer_drop : timer_rise;

   // Source select
   assign event_pulse =
      (src == adtg_pkg::SRC_SW)    ? sw_pulse    :
      (src == adtg_pkg::SRC_TIMER) ? timer_event :
      (src == adtg_pkg::SRC_EXT)   ? ext_rise    : 1'b0;

endmodule

`default_nettype wire

// >>> adtg_trigger_gen.sv
/*
 * Dual unit trigger generator: AXI4-Lite register slave, interleave
 * and trigger start sequencing, timing-violation stop, scan ranges.
 * Assumes two converter units that report completion with one-cycle
 * done pulses on core_clk, and asynchronous trigger pins.
 */
`timescale 1ns/1ns
`default_nettype none

module adtg_trigger_gen #(
   parameter int CNT_W = 8          // Delay counter width
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              reset,
   // AXI4-Lite write address
   input  wire logic [7:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Trigger inputs (pins)
   input  wire logic              timer_trig,
   input  wire logic              ext_trig,
   // Converter unit completion pulses
   input  wire logic              conv_done_a,
   input  wire logic              conv_done_b,
   // Converter unit controls
   output logic                   start_a,
   output logic                   start_b,
   output logic                   stop_a,
   output logic                   stop_b,
   // Scan channel ranges
   output logic [1:0]             scan_first_a,
   output logic [1:0]             scan_last_a,
   output logic [1:0]             scan_first_b,
   output logic [1:0]             scan_last_b
);

   // ==========================================================
   // Helper functions
   // Byte-lane merge of a write into a word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] nw,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // Clamp a channel code to the last input
   function automatic logic [1:0] clamp_ch(input logic [4:0] code);
      logic [1:0] ch;
      ch = (code > {1'b0, adtg_pkg::LAST_CH}) ? 2'h3 : code[1:0];
      return ch;
   endfunction

   // ==========================================================
   // Register storage
   adtg_pkg::adtg_mode_t  mode;      // dual_ctrl_reg2 fields
   logic [CNT_W-1:0]      delay;     // unit_b_delay_count
   adtg_pkg::adtg_scan_t  scan_a;    // Unit A scan range
   adtg_pkg::adtg_scan_t  scan_b;    // Unit B scan range
   logic                  sw_pulse;  // Software trigger pulse
   logic                  viol;      // Sticky violation flag

   // ==========================================================
   // AXI4-Lite write channel capture
   logic [7:0]  aw_addr;             // Held write address
   logic        aw_held;             // Address captured
   logic [31:0] w_data;              // Held write data
   logic [3:0]  w_strb;              // Held strobes
   logic        w_held;              // Data captured
   logic        wr_go;               // Both halves present
   logic        wr_mapped;           // Write address decodes

   assign wr_go     = aw_held & w_held & ~s_axi_bvalid;
   assign wr_mapped = (aw_addr == adtg_pkg::REG_TRIG)  |
                      (aw_addr == adtg_pkg::REG_MODE)  |
                      (aw_addr == adtg_pkg::REG_DELAY) |
                      (aw_addr == adtg_pkg::REG_STATUS)|
                      (aw_addr == adtg_pkg::REG_SCAN);

   // Take address and data in either order, answer after both
   always_ff @(posedge core_clk) begin
      if (reset) begin
         aw_held <= 1'b0;
         aw_addr <= 8'h00;
         w_held  <= 1'b0;
         w_data  <= adtg_pkg::WORD_ZERO;
         w_strb  <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= adtg_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end else if (wr_go) begin
            aw_held <= 1'b0;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end else if (wr_go) begin
            w_held <= 1'b0;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? adtg_pkg::RESP_OKAY
                                      : adtg_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // Ready while the holding slot is free
   assign s_axi_awready = ~aw_held & ~reset;
   assign s_axi_wready  = ~w_held & ~reset;

   // ==========================================================
   // Register writes
   logic wr_trig;                    // Write to dual_ctrl_reg1
   logic wr_mode;                    // Write to dual_ctrl_reg2
   logic wr_delay;                   // Write to dual_ctrl_reg3
   logic wr_status;                  // Write to status
   logic wr_scan;                    // Write to scan ranges
   logic [31:0] mode_word;           // Current mode as a word
   logic [31:0] next_mode_word;      // Mode after merge
   logic [31:0] next_scan_word;      // Scan ranges after merge
   logic [31:0] next_delay_word;     // Delay after merge

   assign wr_trig   = wr_go & (aw_addr == adtg_pkg::REG_TRIG);
   assign wr_mode   = wr_go & (aw_addr == adtg_pkg::REG_MODE);
   assign wr_delay  = wr_go & (aw_addr == adtg_pkg::REG_DELAY);
   assign wr_status = wr_go & (aw_addr == adtg_pkg::REG_STATUS);
   assign wr_scan   = wr_go & (aw_addr == adtg_pkg::REG_SCAN);
   assign mode_word = {28'h0, mode.src, mode.enable, mode.interleave};
   assign next_mode_word  = merge(mode_word, w_data, w_strb);
   assign next_scan_word  = merge({16'h0, scan_b, scan_a},
                                  w_data, w_strb);
   assign next_delay_word = merge({{(32-CNT_W){1'b0}}, delay},
                                  w_data, w_strb);

   // Store the control fields; software pulse lasts one cycle
   always_ff @(posedge core_clk) begin
      if (reset) begin
         mode     <= '0;
         delay    <= '0;
         scan_a   <= '0;
         scan_b   <= '0;
         sw_pulse <= 1'b0;
      end else begin
         sw_pulse <= wr_trig & w_strb[0] &
                     w_data[adtg_pkg::SW_TRIG_BIT];
         if (wr_mode) begin
            mode.interleave <= next_mode_word[adtg_pkg::ILV_BIT];
            mode.enable     <= next_mode_word[adtg_pkg::EN_BIT];
            mode.src <= next_mode_word[adtg_pkg::SRC_LSB +: 2];
         end
         if (wr_delay) begin
            delay <= next_delay_word[CNT_W-1:0];
         end
         if (wr_scan) begin
            scan_a <= next_scan_word[7:0];
            scan_b <= next_scan_word[15:8];
         end
      end
   end

   // ==========================================================
   // Source conditioning
   logic ilv_mode;                   // Interleave active
   logic tsm_mode;                   // Trigger start active
   logic src_event;                  // Selected source event

   assign ilv_mode = mode.interleave & mode.enable;
   assign tsm_mode = ~mode.interleave & mode.enable;

   adtg_source u_source (
      .core_clk    (core_clk),
      .reset       (reset),
      .timer_trig  (timer_trig),
      .ext_trig    (ext_trig),
      .sw_pulse    (sw_pulse),
      .src         (mode.src),
      .timer_fall  (tsm_mode),
      .event_pulse (src_event)
   );

   // ==========================================================
   // Sequencer
   adtg_pkg::adtg_state_t state;     // Interleave wait state
   logic [CNT_W-1:0]      cnt;       // Delay counter
   logic                  next_b;    // Trigger start toggle
   logic                  busy_a;    // Unit A converting
   logic                  busy_b;    // Unit B converting
   logic ilv_bad;                    // Interleave event too early
   logic tsm_bad;                    // Trigger start event too early
   logic fire_a;                     // Issue unit A trigger
   logic fire_b_ilv;                 // Delay matched
   logic fire_b_tsm;                 // Alternate event to B
   logic abort;                      // Violation stop

   assign ilv_bad    = (state == adtg_pkg::ST_WAIT_B) | busy_a;
   assign tsm_bad    = next_b ? busy_b : busy_a;
   assign abort      = src_event & ((ilv_mode & ilv_bad) |
                                    (tsm_mode & tsm_bad));
   assign fire_a     = src_event & ~abort &
                       (ilv_mode | (tsm_mode & ~next_b));
   assign fire_b_tsm = src_event & ~abort & tsm_mode & next_b;
   assign fire_b_ilv = (state == adtg_pkg::ST_WAIT_B) & ilv_mode &
                       ~abort & (cnt == delay);

   // Interleave state: A trigger arms the wait, match or stop ends it
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= adtg_pkg::ST_IDLE;
         cnt   <= '0;
      end else if (fire_a & ilv_mode) begin
         state <= adtg_pkg::ST_WAIT_B;
         cnt   <= '0;
      end else if (state == adtg_pkg::ST_WAIT_B) begin
         if (~ilv_mode | abort | fire_b_ilv) begin
            state <= adtg_pkg::ST_IDLE;
         end else begin
            cnt <= cnt + CNT_W'(1);
         end
      end
   end

   // Alternation in trigger start mode; restarts at A when left
   always_ff @(posedge core_clk) begin
      if (reset) begin
         next_b <= 1'b0;
      end else if (~tsm_mode) begin
         next_b <= 1'b0;
      end else if (fire_a | fire_b_tsm) begin
         next_b <= ~next_b;
      end
   end

   // Busy tracking; a finished B is kept even if stopped after
   always_ff @(posedge core_clk) begin
      if (reset) begin
         busy_a <= 1'b0;
         busy_b <= 1'b0;
      end else begin
         busy_a <= fire_a | (busy_a & ~conv_done_a & ~abort);
         busy_b <= fire_b_ilv | fire_b_tsm |
                   (busy_b & ~conv_done_b & ~abort);
      end
   end

   // Trigger and stop outputs, one cycle each
   always_ff @(posedge core_clk) begin
      if (reset) begin
         start_a <= 1'b0;
         start_b <= 1'b0;
         stop_a  <= 1'b0;
         stop_b  <= 1'b0;
      end else begin
         start_a <= fire_a;
         start_b <= fire_b_ilv | fire_b_tsm;
         stop_a  <= abort & busy_a;
         stop_b  <= abort & busy_b;
      end
   end

   // Sticky violation flag, set wins over clear
   always_ff @(posedge core_clk) begin
      if (reset) begin
         viol <= 1'b0;
      end else if (abort) begin
         viol <= 1'b1;
      end else if (wr_status & w_strb[0] &
                   w_data[adtg_pkg::STS_VIOL]) begin
         viol <= 1'b0;
      end
   end

   // ==========================================================
   // Scan ranges: clamped first channel and clamped last channel
   always_ff @(posedge core_clk) begin
      if (reset) begin
         scan_first_a <= 2'h0;
         scan_last_a  <= 2'h0;
         scan_first_b <= 2'h0;
         scan_last_b  <= 2'h0;
      end else begin
         scan_first_a <= clamp_ch({1'b0, scan_a.start});
         scan_last_a  <= clamp_ch({1'b0, scan_a.start} +
                                  {1'b0, scan_a.width});
         scan_first_b <= clamp_ch({1'b0, scan_b.start});
         scan_last_b  <= clamp_ch({1'b0, scan_b.start} +
                                  {1'b0, scan_b.width});
      end
   end

   // ==========================================================
   // AXI4-Lite read channel
   logic [31:0] status_word;         // Live state
   logic [31:0] rd_word;             // Selected read value
   logic        rd_mapped;           // Read address decodes

   assign status_word = {{(24-CNT_W){1'b0}}, cnt, 3'h0, viol,
                         busy_b, busy_a, next_b, state};
   assign rd_mapped = (s_axi_araddr == adtg_pkg::REG_TRIG)  |
                      (s_axi_araddr == adtg_pkg::REG_MODE)  |
                      (s_axi_araddr == adtg_pkg::REG_DELAY) |
                      (s_axi_araddr == adtg_pkg::REG_STATUS)|
                      (s_axi_araddr == adtg_pkg::REG_SCAN);
   assign rd_word =
      (s_axi_araddr == adtg_pkg::REG_MODE)   ? mode_word :
      (s_axi_araddr == adtg_pkg::REG_DELAY)  ?
         {{(32-CNT_W){1'b0}}, delay} :
      (s_axi_araddr == adtg_pkg::REG_STATUS) ? status_word :
      (s_axi_araddr == adtg_pkg::REG_SCAN)   ?
         {16'h0, scan_b, scan_a} : adtg_pkg::WORD_ZERO;

   // One read at a time; answer the cycle after the address
   always_ff @(posedge core_clk) begin
      if (reset) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= adtg_pkg::WORD_ZERO;
         s_axi_rresp  <= adtg_pkg::RESP_OKAY;
      end else if (s_axi_arvalid & s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_mapped ? adtg_pkg::RESP_OKAY
                                   : adtg_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   assign s_axi_arready = ~s_axi_rvalid & ~reset;

endmodule

`default_nettype wire

// >>> adtg_trigger_gen_asserts.sv
/* Port checker for the dual unit trigger generator.
   Assumes it is bound to every adtg_trigger_gen instance. */
`timescale 1ns/1ns
`default_nettype none
module adtg_trigger_gen_asserts (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset,
   // Register bus
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // Unit controls
   input wire logic start_a,
   input wire logic start_b,
   input wire logic stop_a,
   input wire logic stop_b
);
   // ============================================
   // Trigger and bus properties
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (reset);
   a_start_a_pulse: assert property (start_a |=> !start_a)
      else $error("start_a held past one cycle");
   a_start_b_pulse: assert property (start_b |=> !start_b)
      else $error("start_b held past one cycle");
   a_ab_apart: assert property (!(start_a && start_b))
      else $error("both units started together");
   a_stop_no_start: assert property
      ((stop_a || stop_b) |-> !start_a && !start_b)
      else $error("start issued with a stop");
   a_quiet_after_reset: assert property ($past(reset) |->
      !start_a && !start_b && !s_axi_bvalid && !s_axi_rvalid)
      else $error("output active right after reset");
   a_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response repeated");
   a_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
      else $error("read data repeated");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read address taken while data pending");
   a_r_answer: assert property
      (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
endmodule
bind adtg_trigger_gen adtg_trigger_gen_asserts u_chk (.core_clk, .reset,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
   .s_axi_bvalid, .s_axi_bready, .start_a, .start_b, .stop_a, .stop_b);
`default_nettype wire

// >>> adtg_conv_model.sv
/* Converter unit model: converts LAT cycles per start, aborts on stop.
   Assumes one-cycle start and stop pulses on core_clk. */
`timescale 1ns/1ns
`default_nettype none
module adtg_conv_model #(
   parameter int LAT = 8 // Conversion length in cycles
) (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic reset,
   // Trigger side
   input  wire logic start,
   input  wire logic stop,
   // Completion pulse
   output logic      done
);
   logic busy; // Conversion under way
   int   cnt;  // Cycles left
   // Convert on start, drop the conversion on stop
   always @(posedge core_clk) begin
      done <= 1'b0;
      if (reset || stop) begin
         busy <= 1'b0;
      end else if (start) begin
         busy <= 1'b1;
         cnt  <= LAT;
      end else if (busy && cnt == 1) begin
         busy <= 1'b0;
         done <= 1'b1;
      end else begin
         cnt <= cnt - 1;
      end
   end
endmodule
`default_nettype wire

// >>> tb_adtg_trigger_gen.sv
/* Testbench for the trigger generator with two converter models.
   Assumes the register map and encodings of adtg_pkg. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g,e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
   $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tb_adtg_trigger_gen;
   // ============================================
   // Signals
   logic        core_clk = 0, reset = 1, timer_trig = 0, ext_trig = 0;
   logic [7:0]  awaddr = 0, araddr = 0;
   logic        awvalid = 0, wvalid = 0, arvalid = 0;
   logic [31:0] wdata = 0, rdata, rdv;
   logic [1:0]  bresp, rresp, rr, rb, fa, la, fb, lb;
   logic        awready, wready, arready, bvalid, rvalid, done_a, done_b;
   logic        start_a, start_b, stop_a, stop_b;
   int          n_errors = 0, n_compared = 0, cyc = 0, t_a, t_b;
   int          na = 0, nb = 0, nsa = 0, ndb = 0, ea = 0, eb = 0;
   int          dl[3] = '{0, 2, 5};
   // Design and converter units
   adtg_trigger_gen u_dut (.core_clk(core_clk), .reset(reset),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .timer_trig(timer_trig),
      .ext_trig(ext_trig), .conv_done_a(done_a), .conv_done_b(done_b),
      .start_a(start_a), .start_b(start_b), .stop_a(stop_a), .stop_b(stop_b),
      .scan_first_a(fa), .scan_last_a(la), .scan_first_b(fb),
      .scan_last_b(lb));
   adtg_conv_model #(.LAT(20)) u_unit_a (.core_clk(core_clk), .reset(reset),
      .start(start_a), .stop(stop_a), .done(done_a));
   adtg_conv_model #(.LAT(30)) u_unit_b (.core_clk(core_clk), .reset(reset),
      .start(start_b), .stop(stop_b), .done(done_b));
   always #5 core_clk = ~core_clk;
   // Count pulses, stamp starts, cut a hang short
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (start_a) begin na <= na + 1; t_a <= cyc; end
      if (start_b) begin nb <= nb + 1; t_b <= cyc; end
      if (stop_a) nsa <= nsa + 1;
      if (done_b) ndb <= ndb + 1;
      if (cyc > 20000) begin n_errors++; stop_test(); end
   end
   // ============================================
   // Bus and trigger tasks
   task automatic pass(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic ha, hw, hb;
      awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
      do begin
         @(negedge core_clk);
         ha = awvalid && awready; hw = wvalid && wready; hb = bvalid;
         rb = bresp;
         @(posedge core_clk);
         if (ha) awvalid <= 1'b0;
         if (hw) wvalid <= 1'b0;
      end while (!hb);
   endtask
   task automatic rdr(input logic [7:0] a);
      logic ha, hr;
      araddr <= a; arvalid <= 1'b1;
      do begin
         @(negedge core_clk);
         ha = arvalid && arready; hr = rvalid; rdv = rdata; rr = rresp;
         @(posedge core_clk);
         if (ha) arvalid <= 1'b0;
      end while (!hr);
   endtask
   // Disable, set delay, then set mode
   task automatic cfg(input int d, input int m);
      wr(adtg_pkg::REG_MODE, 32'h0000_0000);
      wr(adtg_pkg::REG_DELAY, 32'(d));
      wr(adtg_pkg::REG_MODE, 32'(m));
   endtask
   // One source event, then room for both conversions
   task automatic ev(input int s, input bit k);
      if (s == 0) wr(adtg_pkg::REG_TRIG, 32'h0000_0001);
      else if (s == 1) timer_trig <= 1'b1;
      else ext_trig <= 1'b1;
      pass(10);
      if (k) `CHK(na + nb, ea + eb)
      timer_trig <= 1'b0;
      ext_trig <= 1'b0;
      pass(80);
   endtask
   task automatic stop_test();
      $display("Mismatches %0d, compares %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ============================================
   // Main sequence
   initial begin
      pass(12);
      reset <= 1'b0;
      pass(1);
      rdr(adtg_pkg::REG_MODE);
      `CHK(rdv, adtg_pkg::WORD_ZERO)
      rdr(adtg_pkg::REG_DELAY);
      `CHK(rdv, adtg_pkg::WORD_ZERO)
      rdr(8'h14);
      `CHK({rr, rdv}, {adtg_pkg::RESP_SLVERR, adtg_pkg::WORD_ZERO})
      wr(8'h14, 32'h0000_00ff);
      `CHK(rb, adtg_pkg::RESP_SLVERR)
      foreach (dl[i]) begin
         cfg(dl[i], 3);
         ev(0, 0);
         ea++; eb++;
         `CHK(na, ea)
         `CHK(t_b - t_a, dl[i] + 1)
      end
      for (int s = 1; s < 3; s++) begin
         cfg(3, 4 * s + 3);
         ev(s, 0);
         ea++; eb++;
         `CHK(t_b - t_a, 4)
      end
      cfg(2, 3);
      wr(adtg_pkg::REG_TRIG, 32'h0000_0001);
      pass(8);
      wr(adtg_pkg::REG_MODE, 32'h0000_0000);
      pass(80);
      ea++; eb++;
      `CHK(ndb, eb)
      cfg(40, 3);
      wr(adtg_pkg::REG_TRIG, 32'h0000_0001);
      wr(adtg_pkg::REG_MODE, 32'h0000_0001);
      pass(80);
      ea++;
      `CHK({na, nb}, {ea, eb})
      wr(adtg_pkg::REG_MODE, 32'h0000_0003);
      ev(0, 0);
      ea++; eb++;
      `CHK({na, nb}, {ea, eb})
      for (int s = 0; s < 3; s++) begin
         cfg(0, 4 * s + 2);
         for (int k = 0; k < 4; k++) begin
            ev(s, s == 1);
            if (k % 2 == 0) ea++;
            else eb++;
            `CHK({na, nb}, {ea, eb})
         end
      end
      wr(adtg_pkg::REG_SCAN, 32'h0000_3211);
      pass(2);
      `CHK({fa, la, fb, lb}, 8'h6b)
      wr(adtg_pkg::REG_SCAN, 32'h0000_0003);
      pass(2);
      `CHK({fa, la, fb, lb}, 8'hf0)
      cfg(40, 3);
      wr(adtg_pkg::REG_TRIG, 32'h0000_0001);
      ev(0, 0);
      ea++;
      `CHK({na, nb, nsa}, {ea, eb, 32'h0000_0001})
      rdr(adtg_pkg::REG_STATUS);
      `CHK(rdv[adtg_pkg::STS_VIOL], 1'b1)
      wr(adtg_pkg::REG_STATUS, 32'h0000_0010);
      rdr(adtg_pkg::REG_STATUS);
      `CHK(rdv[adtg_pkg::STS_VIOL], 1'b0)
      stop_test();
   end
endmodule
`default_nettype wire
